// ==== dcgi_config_bank.sv ====
// Shared configuration bank with the global interrupt summary word.
// Assumes byte-enabled 32-bit word accesses; channels and timer sit outside.

module dcgi_config_bank
    import dcgi_pkg::*;
#(
    parameter logic [7:0] SILICON_REV = 8'h01, // Arbitrary value
    parameter logic [7:0] PART_ID     = 8'h5A  // Arbitrary value
) (
    input  logic        mclk,
    input  logic        reset,
    input  logic [7:0]  reg_addr,
    input  logic [3:0]  reg_be,
    input  logic        reg_wr,
    input  logic        reg_rd,
    input  logic [31:0] reg_wdata,
    input  logic        reg_win_local,
    input  logic [2:0]  reg_win_chan,
    output logic [31:0] reg_rdata,
    output logic        reg_rvalid,
    input  logic [7:0]  ch_rx_req,
    input  logic [7:0]  ch_rxto_req,
    input  logic [7:0]  ch_tx_req,
    input  logic [7:0]  ch_ms_req,
    input  logic        wake_activity,
    input  logic        timer_timeout,
    input  logic [15:0] pin_in,
    output logic [7:0]  chan_soft_reset,
    output logic [7:0]  oversample_eight,
    output logic [7:0]  oversample_four,
    output logic [7:0]  chan_sleep,
    output logic [15:0] timer_divisor,
    output logic [3:0]  timer_cmd,
    output logic        timer_cmd_stb,
    output logic        timer_irq_en,
    output logic [7:0]  eeprom_ctrl,
    output logic [15:0] pin_out,
    output logic [15:0] pin_oe
);

    function automatic logic [2:0] src_code(input logic rx, input logic to, input logic tx,
                                            input logic ms, input logic pin, input logic tmr);
        logic [2:0] c;
        c = CODE_NONE;
        if (tmr) c = CODE_TIMER;
        if (pin) c = CODE_PIN;
        if (ms)  c = CODE_MODEM;
        if (tx)  c = CODE_TX;
        if (to)  c = CODE_RXTO;
        if (rx)  c = CODE_RX;
        return c;
    endfunction

    function automatic logic hit(input logic en, input logic [7:0] off);
        return en && (reg_addr[7:2] == off[7:2]) && reg_be[off[1:0]];
    endfunction

    function automatic logic [7:0] lane(input logic [7:0] off);
        return reg_wdata[{off[1:0], 3'b000} +: 8];
    endfunction

    function automatic logic [7:0] upd(input logic [7:0] old, input logic [7:0] off);
        return hit(reg_wr, off) ? lane(off) : old;
    endfunction

    logic [31:0] irq_word_r;
    logic [31:0] reg_rdata_r;
    logic        reg_rvalid_r;
    logic [7:0]  srst_r;
    logic [7:0]  ovs8_r;
    logic [7:0]  ovs4_r;
    logic [7:0]  sleep_r;
    logic [7:0]  eep_r;
    logic [15:0] div_r;
    logic [15:0] mask_r;
    logic [15:0] lvl_r;
    logic [15:0] tri_r;
    logic [15:0] inv_r;
    logic [15:0] dir_r;
    logic [15:0] od_r;
    logic [15:0] pin_prev_r;
    logic        wake_pend_r;
    logic        asleep_r;
    logic        pin_pend_r;
    logic        tmr_pend_r;
    logic        tmr_ien_r;
    logic [3:0]  tcmd_r;
    logic        tcmd_stb_r;

    logic [7:0]  map_q [OFF_IRQ_FLAGS:OFF_RSVD_TAIL];
    logic [23:0] code_nxt;
    logic [7:0]  flag_nxt;
    logic [31:0] irq_nxt;
    logic [31:0] rdata_nxt;
    logic [7:0]  win_mask;
    logic [15:0] pin_eff;
    logic [15:0] lvl_view;
    logic        pin_evt;
    logic        wake_evt;
    logic        tmr_show;
    logic        rd_flags;
    logic        rd_lvl;
    logic        rd_tcmd;
    logic        wr_tcmd;
    logic [3:0]  tcmd_nxt;
    logic [7:0]  tcmd_byte;

    // Summary word is rebuilt every cycle from live sources
    for (genvar c = 0; c < 8; c++) begin : g_code
        assign code_nxt[3*c +: 3] = src_code(ch_rx_req[c], ch_rxto_req[c], ch_tx_req[c],
                                             ch_ms_req[c], (c == 0) && pin_pend_r,
                                             (c == 0) && tmr_show);
    end

    assign tmr_show = tmr_pend_r & tmr_ien_r;
    assign flag_nxt = (ch_rx_req | ch_rxto_req | ch_tx_req | ch_ms_req)
                    | {7'h00, wake_pend_r | pin_pend_r | tmr_show};
    assign irq_nxt  = {code_nxt, flag_nxt};

    // Read side effects; the helpers read the bus inside, so a plain assign would miss changes
    always_comb begin
        rd_flags  = hit(reg_rd, OFF_IRQ_FLAGS);
        rd_lvl    = hit(reg_rd, OFF_LVL_LO) | hit(reg_rd, OFF_LVL_HI);
        rd_tcmd   = hit(reg_rd, OFF_TMR_CMD);
        wr_tcmd   = hit(reg_wr, OFF_TMR_CMD);
        tcmd_byte = lane(OFF_TMR_CMD);
        tcmd_nxt  = tcmd_byte[3:0];
    end

    // Wake after the whole device slept: sleep bits dropped or line activity
    assign wake_evt = asleep_r & ((sleep_r != SLEEP_ALL) | wake_activity);

    // Pins
    assign pin_eff  = pin_in ^ inv_r;
    assign pin_evt  = |((pin_eff ^ pin_prev_r) & mask_r & dir_r);
    assign lvl_view = (dir_r & pin_eff) | (~dir_r & lvl_r);

    // Channel window may only touch its own bit
    assign win_mask = reg_win_local ? (8'h01 << reg_win_chan) : 8'hFF;

    // Read map; write-only and reserved bytes read zero
    assign map_q[OFF_IRQ_FLAGS] = irq_word_r[7:0];
    assign map_q[OFF_IRQ_B1]    = irq_word_r[15:8];
    assign map_q[OFF_IRQ_B2]    = irq_word_r[23:16];
    assign map_q[OFF_IRQ_B3]    = irq_word_r[31:24];
    assign map_q[OFF_TMR_CMD]   = tmr_show ? TMR_STATUS : RST_BYTE;
    assign map_q[OFF_RSVD_A]    = RST_BYTE;
    assign map_q[OFF_DIV_LO]    = div_r[7:0];
    assign map_q[OFF_DIV_HI]    = div_r[15:8];
    assign map_q[OFF_OVS8]      = ovs8_r;
    assign map_q[OFF_OVS4]      = ovs4_r;
    assign map_q[OFF_SRST]      = RST_BYTE;
    assign map_q[OFF_SLEEP]     = sleep_r;
    assign map_q[OFF_REV]       = SILICON_REV;
    assign map_q[OFF_PART_ID]   = PART_ID;
    assign map_q[OFF_EEPROM]    = eep_r;
    assign map_q[OFF_MASK_LO]   = mask_r[7:0];
    assign map_q[OFF_LVL_LO]    = lvl_view[7:0];
    assign map_q[OFF_TRI_LO]    = tri_r[7:0];
    assign map_q[OFF_INV_LO]    = inv_r[7:0];
    assign map_q[OFF_DIR_LO]    = dir_r[7:0];
    assign map_q[OFF_OD_LO]     = od_r[7:0];
    assign map_q[OFF_MASK_HI]   = mask_r[15:8];
    assign map_q[OFF_LVL_HI]    = lvl_view[15:8];
    assign map_q[OFF_TRI_HI]    = tri_r[15:8];
    assign map_q[OFF_INV_HI]    = inv_r[15:8];
    assign map_q[OFF_DIR_HI]    = dir_r[15:8];
    assign map_q[OFF_OD_HI]     = od_r[15:8];
    assign map_q[OFF_RSVD_TAIL] = RST_BYTE;

    for (genvar l = 0; l < 4; l++) begin : g_lane
        logic [7:0] ba;
        logic       inr;
        assign ba  = {reg_addr[7:2], 2'(l)};
        assign inr = (ba >= OFF_IRQ_FLAGS) && (ba <= OFF_RSVD_TAIL) && reg_be[l];
        // All four bytes come from one snapshot of the summary word
        assign rdata_nxt[8*l +: 8] = inr ? map_q[ba] : RST_BYTE;
    end

    // Host interface
    always_ff @(posedge mclk) begin
        if (reset) begin
            reg_rdata_r  <= RST_IRQ;
            reg_rvalid_r <= 1'b0;
        end else begin
            reg_rdata_r  <= reg_rd ? rdata_nxt : RST_IRQ;
            reg_rvalid_r <= reg_rd;
        end
    end

    // Read-only bytes have no write path at all
    always_ff @(posedge mclk) begin
        if (reset) irq_word_r <= RST_IRQ;
        else       irq_word_r <= irq_nxt;
    end

    // Per-channel bytes
    always_ff @(posedge mclk) begin
        if (reset) begin
            ovs8_r  <= RST_BYTE;
            ovs4_r  <= RST_BYTE;
            sleep_r <= RST_BYTE;
            srst_r  <= RST_BYTE;
        end else begin
            if (hit(reg_wr, OFF_OVS8))
                ovs8_r <= (ovs8_r & ~win_mask) | (lane(OFF_OVS8) & win_mask);
            if (hit(reg_wr, OFF_OVS4))
                ovs4_r <= (ovs4_r & ~win_mask) | (lane(OFF_OVS4) & win_mask);
            if (hit(reg_wr, OFF_SLEEP))
                sleep_r <= (sleep_r & ~win_mask) | (lane(OFF_SLEEP) & win_mask);
            // One-cycle pulse, then self-clear
            srst_r <= hit(reg_wr, OFF_SRST) ? (lane(OFF_SRST) & win_mask) : RST_BYTE;
        end
    end

    // Plain read/write bytes
    always_ff @(posedge mclk) begin
        if (reset) begin
            div_r  <= RST_PAIR;
            eep_r  <= RST_BYTE;
            mask_r <= RST_PAIR;
            lvl_r  <= RST_PAIR;
            tri_r  <= RST_PAIR;
            inv_r  <= RST_PAIR;
            dir_r  <= RST_DIR;
            od_r   <= RST_PAIR;
        end else begin
            div_r  <= {upd(div_r[15:8], OFF_DIV_HI), upd(div_r[7:0], OFF_DIV_LO)};
            eep_r  <= upd(eep_r, OFF_EEPROM);
            mask_r <= {upd(mask_r[15:8], OFF_MASK_HI), upd(mask_r[7:0], OFF_MASK_LO)};
            lvl_r  <= {upd(lvl_r[15:8], OFF_LVL_HI), upd(lvl_r[7:0], OFF_LVL_LO)};
            tri_r  <= {upd(tri_r[15:8], OFF_TRI_HI), upd(tri_r[7:0], OFF_TRI_LO)};
            inv_r  <= {upd(inv_r[15:8], OFF_INV_HI), upd(inv_r[7:0], OFF_INV_LO)};
            dir_r  <= {upd(dir_r[15:8], OFF_DIR_HI), upd(dir_r[7:0], OFF_DIR_LO)};
            od_r   <= {upd(od_r[15:8], OFF_OD_HI), upd(od_r[7:0], OFF_OD_LO)};
        end
    end

    // Global events; a new event beats a clearing read in the same cycle
    always_ff @(posedge mclk) begin
        if (reset) begin
            wake_pend_r <= 1'b0;
            asleep_r    <= 1'b0;
            pin_pend_r  <= 1'b0;
            pin_prev_r  <= RST_PAIR;
        end else begin
            wake_pend_r <= wake_evt | (wake_pend_r & ~rd_flags);
            asleep_r    <= (sleep_r == SLEEP_ALL) & ~wake_activity & ~wake_evt;
            pin_pend_r  <= pin_evt | (pin_pend_r & ~rd_lvl);
            pin_prev_r  <= pin_eff;
        end
    end

    // Timer interrupt state; the counter itself lives outside
    always_ff @(posedge mclk) begin
        if (reset) begin
            tmr_pend_r <= 1'b0;
            tmr_ien_r  <= 1'b0;
            tcmd_r     <= 4'h0;
            tcmd_stb_r <= 1'b0;
        end else begin
            tmr_pend_r <= timer_timeout | (tmr_pend_r & ~rd_tcmd & ~(wr_tcmd && tcmd_nxt == TCMD_RESET));
            if (wr_tcmd && tcmd_nxt == TCMD_IRQ_EN)
                tmr_ien_r <= 1'b1;
            else if (wr_tcmd && (tcmd_nxt == TCMD_IRQ_DIS || tcmd_nxt == TCMD_RESET))
                tmr_ien_r <= 1'b0;
            tcmd_r     <= wr_tcmd ? tcmd_nxt : 4'h0;
            tcmd_stb_r <= wr_tcmd && (tcmd_nxt != 4'h0);
        end
    end

    assign reg_rdata        = reg_rdata_r;
    assign reg_rvalid       = reg_rvalid_r;
    assign chan_soft_reset  = srst_r;
    assign oversample_eight = ovs8_r;
    assign oversample_four  = ovs4_r;
    assign chan_sleep       = sleep_r;
    assign timer_divisor    = div_r;
    assign timer_cmd        = tcmd_r;
    assign timer_cmd_stb    = tcmd_stb_r;
    assign timer_irq_en     = tmr_ien_r;
    assign eeprom_ctrl      = eep_r;
    assign pin_out          = lvl_r;
    // Open drain drives only the low level
    assign pin_oe           = ~dir_r & ~tri_r & ~(od_r & lvl_r);

    irq_reset_zero_a: assert property (
        @(posedge mclk) reset |=> (irq_word_r == RST_IRQ && reg_rdata == RST_IRQ))
        else $error("summary word not zero after reset");

    flag_or_a: assert property (
        @(posedge mclk) disable iff (reset)
        ##1 irq_word_r[7:1] == $past(ch_rx_req[7:1] | ch_rxto_req[7:1] | ch_tx_req[7:1] | ch_ms_req[7:1]))
        else $error("indicator bit differs from channel requests");

    code_prio_a: assert property (
        @(posedge mclk) disable iff (reset)
        (ch_rx_req[4] && ch_ms_req[4]) |=> irq_word_r[22:20] == CODE_RX)
        else $error("receive code did not win over modem status");

    timer_code_a: assert property (
        @(posedge mclk) disable iff (reset)
        (tmr_show && !pin_pend_r && !ch_rx_req[0] && !ch_rxto_req[0] && !ch_tx_req[0] && !ch_ms_req[0])
        |=> irq_word_r[10:8] == CODE_TIMER && irq_word_r[0])
        else $error("timer event not shown in channel 0 code");

    wake_clear_a: assert property (
        @(posedge mclk) disable iff (reset)
        (rd_flags && !wake_evt) |=> !wake_pend_r)
        else $error("wake-up pending survived indicator read");

    wake_raise_a: assert property (
        @(posedge mclk) disable iff (reset)
        (asleep_r && (wake_activity || chan_sleep != SLEEP_ALL)) |=> wake_pend_r ##1 irq_word_r[0])
        else $error("no wake-up interrupt after full sleep");

    srst_self_a: assert property (
        @(posedge mclk) disable iff (reset)
        (chan_soft_reset != RST_BYTE) |=> (chan_soft_reset == RST_BYTE || $past(reg_wr)))
        else $error("soft reset bits did not self-clear");

    win_local_a: assert property (
        @(posedge mclk) disable iff (reset)
        (hit(reg_wr, OFF_SLEEP) && reg_win_local) |=> ((sleep_r ^ $past(sleep_r)) & ~$past(win_mask)) == 8'h00)
        else $error("channel window changed another channel's sleep bit");

    pin_clear_a: assert property (
        @(posedge mclk) disable iff (reset)
        (rd_lvl && !pin_evt) |=> !pin_pend_r)
        else $error("pin interrupt survived level read");

    tmr_clear_a: assert property (
        @(posedge mclk) disable iff (reset)
        (rd_tcmd && !timer_timeout) |=> !tmr_pend_r)
        else $error("timer interrupt survived command read");

    rsvd_read_a: assert property (
        @(posedge mclk) disable iff (reset)
        (reg_rd && reg_addr[7:2] == OFF_RSVD_TAIL[7:2]) |=> reg_rvalid && reg_rdata[31:24] == RST_BYTE)
        else $error("reserved byte read nonzero");

    id_fixed_a: assert property (
        @(posedge mclk) disable iff (reset)
        (reg_rd && reg_addr[7:2] == OFF_REV[7:2] && reg_be[1]) |=> reg_rdata[15:8] == PART_ID)
        else $error("identifier byte changed");

    mask_write_a: assert property (
        @(posedge mclk) disable iff (reset)
        hit(reg_wr, OFF_MASK_HI) |=> mask_r[15:8] == $past(reg_wdata[15:8]))
        else $error("high pin mask did not take written value");

    srst_pulse_a: assert property (
        @(posedge mclk) disable iff (reset)
        hit(reg_wr, OFF_SRST) |=> chan_soft_reset == ($past(reg_wdata[23:16]) & $past(win_mask)))
        else $error("soft reset pulse differs from written bits");

    od_low_only_a: assert property (
        @(posedge mclk) disable iff (reset)
        (od_r & lvl_r & pin_oe) == RST_PAIR)
        else $error("open-drain pin driven high");

    tmr_status_a: assert property (
        @(posedge mclk) disable iff (reset)
        (rd_tcmd && !reg_wr) |=> reg_rdata[7:0] == {7'h00, $past(tmr_show)})
        else $error("timer command byte status wrong");

endmodule

// ==== dcgi_pkg.sv ====
// Constants for the shared device configuration bank of the eight-channel bridge.
// Assumes byte offsets A7:A0 within one channel window and a single mclk domain.
//
// Notes on behaviour
// - A 32-bit read-only interrupt summary sits at offsets 0x080 to 0x083.
// - Every summary bit reads zero after reset until an interrupt arises.
// - Indicator byte has one bit per channel, bit 0 channel 0, bit 7 channel 7.
// - A channel's indicator is the OR of its transmit, receive, receive-timeout and modem requests, plus wake-up, pin and timer for channel 0.
// - Indicator clears only when the channel's own source clears, never by writes to 0x080 to 0x083.
// - Three-bit source codes fill bits 31:8, channel 0 in 10:8, channel 7 in 31:29.
// - Channel 0's code expresses six causes plus a no-interrupt value; the codes of channels 1 to 7 express four.
// - Timer and pin events are reported only in channel 0's code; wake-up only in indicator bit 0.
// - Wake-up interrupt is raised on waking after all eight channels slept.
// - Reading the indicator byte clears the pending wake-up interrupt.
// - One 32-bit read returns indicator and all codes from the same cycle.
// - Soft-reset register is write-only; written ones reset channels then self-clear.
// - Channel-window accesses change only that channel's bit at 0x088 to 0x08B.
// - Pin interrupt mask, low 0x08F, high 0x095, read/write, reset zero.
// - Pin level register, low 0x090, high 0x096, read/write, reset zero.
// - Pin output tristate control, low 0x091, high 0x097, read/write, reset zero.
// - Pin input inversion select, low 0x092, high 0x098, read/write, reset zero.
// - Pin open-drain enable, low 0x094, high 0x09A, read/write, reset zero.
// - Codes 1 rx, 2 timeout, 3 tx, 4 modem, 6 pin, 7 timer; lower wins.
// - Pending pin interrupt clears when the pin level register is read.
// - Pending timer interrupt clears when the timer command register is read.

package dcgi_pkg;

    localparam logic [7:0] OFF_IRQ_FLAGS = 8'h80;
    localparam logic [7:0] OFF_IRQ_B1    = 8'h81;
    localparam logic [7:0] OFF_IRQ_B2    = 8'h82;
    localparam logic [7:0] OFF_IRQ_B3    = 8'h83;
    localparam logic [7:0] OFF_TMR_CMD   = 8'h84;
    localparam logic [7:0] OFF_RSVD_A    = 8'h85;
    localparam logic [7:0] OFF_DIV_LO    = 8'h86;
    localparam logic [7:0] OFF_DIV_HI    = 8'h87;
    localparam logic [7:0] OFF_OVS8      = 8'h88;
    localparam logic [7:0] OFF_OVS4      = 8'h89;
    localparam logic [7:0] OFF_SRST      = 8'h8A;
    localparam logic [7:0] OFF_SLEEP     = 8'h8B;
    localparam logic [7:0] OFF_REV       = 8'h8C;
    localparam logic [7:0] OFF_PART_ID   = 8'h8D;
    localparam logic [7:0] OFF_EEPROM    = 8'h8E;
    localparam logic [7:0] OFF_MASK_LO   = 8'h8F;
    localparam logic [7:0] OFF_LVL_LO    = 8'h90;
    localparam logic [7:0] OFF_TRI_LO    = 8'h91;
    localparam logic [7:0] OFF_INV_LO    = 8'h92;
    localparam logic [7:0] OFF_DIR_LO    = 8'h93;
    localparam logic [7:0] OFF_OD_LO     = 8'h94;
    localparam logic [7:0] OFF_MASK_HI   = 8'h95;
    localparam logic [7:0] OFF_LVL_HI    = 8'h96;
    localparam logic [7:0] OFF_TRI_HI    = 8'h97;
    localparam logic [7:0] OFF_INV_HI    = 8'h98;
    localparam logic [7:0] OFF_DIR_HI    = 8'h99;
    localparam logic [7:0] OFF_OD_HI     = 8'h9A;
    localparam logic [7:0] OFF_RSVD_TAIL = 8'h9B;

    localparam logic [7:0]  RST_BYTE   = 8'h00;
    localparam logic [15:0] RST_PAIR   = 16'h0000;
    localparam logic [15:0] RST_DIR    = 16'hFFFF;
    localparam logic [31:0] RST_IRQ    = 32'h0000_0000;
    localparam logic [7:0]  SLEEP_ALL  = 8'hFF;
    localparam logic [7:0]  TMR_STATUS = 8'h01;

    typedef enum logic [2:0] {
        CODE_NONE  = 3'h0,
        CODE_RX    = 3'h1,
        CODE_RXTO  = 3'h2,
        CODE_TX    = 3'h3,
        CODE_MODEM = 3'h4,
        CODE_PIN   = 3'h6,
        CODE_TIMER = 3'h7
    } dcgi_code_t;

    localparam logic [3:0] TCMD_IRQ_EN  = 4'h1;
    localparam logic [3:0] TCMD_IRQ_DIS = 4'h2;
    localparam logic [3:0] TCMD_RESET   = 4'hB;

endpackage

// ==== dcgi_host_model.sv ====
// Host bus master model for the configuration bank.
// Assumes each task starts just after a rising mclk edge.
module dcgi_host_model (
    input  logic        mclk,
    output logic [7:0]  reg_addr,
    output logic [3:0]  reg_be,
    output logic        reg_wr,
    output logic        reg_rd,
    output logic [31:0] reg_wdata,
    output logic        reg_win_local,
    output logic [2:0]  reg_win_chan,
    input  logic [31:0] reg_rdata,
    input  logic        reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        reg_addr = 8'h00;
        reg_be = 4'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 32'h0000_0000;
        reg_win_local = 1'b0;
        reg_win_chan = 3'h0;
    end

    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
                      input logic loc, input logic [2:0] ch);
        // Idle edge first, so a strobe is never dropped and raised in one step
        @(posedge mclk);
        #1;
        reg_addr = a;
        reg_be = be;
        reg_wdata = d;
        reg_win_local = loc;
        reg_win_chan = ch;
        reg_wr = 1'b1;
        @(posedge mclk);
        #1;
        reg_wr = 1'b0;
        // Released data must not look like the last value
        reg_wdata = ~d;
    endtask

    // Reads carry clear side effects
    task automatic rd(input logic [7:0] a, input logic [3:0] be, output logic [31:0] d, output logic ok);
        int i;
        @(posedge mclk);
        #1;
        reg_addr = a;
        reg_be = be;
        reg_rd = 1'b1;
        @(posedge mclk);
        #1;
        reg_rd = 1'b0;
        ok = 1'b0;
        d = 32'hXXXX_XXXX;
        for (i = 0; i < 4 && !ok; i++) begin
            if (reg_rvalid === 1'b1) begin
                d = reg_rdata;
                ok = 1'b1;
            end else begin
                @(posedge mclk);
                #1;
            end
        end
    endtask
endmodule

// ==== test_device_config_and_global_irq.sv ====
// Self-checking bench for the configuration bank and interrupt summary.
// Assumes the host model drives the register bus; wake_activity stays low.
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch t=%0t got %h exp %h", $time, g, e); end end

module test_device_config_and_global_irq import dcgi_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    // Arbitrary identity values
    localparam logic [7:0] REV = 8'h3C;
    localparam logic [7:0] PID = 8'h77;

    logic mclk = 1'b0, reset = 1'b1, reg_wr, reg_rd, reg_win_local, reg_rvalid;
    logic wake_activity = 1'b0, timer_timeout = 1'b0, timer_cmd_stb, timer_irq_en;
    logic [2:0] reg_win_chan;
    logic [3:0] reg_be, timer_cmd;
    logic [7:0] reg_addr, chan_soft_reset, oversample_eight, oversample_four, chan_sleep, eeprom_ctrl;
    logic [7:0] ch_rx_req = 8'h00, ch_rxto_req = 8'h00, ch_tx_req = 8'h00, ch_ms_req = 8'h00;
    logic [15:0] pin_in = 16'h0000, timer_divisor, pin_out, pin_oe;
    logic [31:0] reg_wdata, reg_rdata;
    int err_total = 0;
    int comparisons = 0;

    always #4 mclk = ~mclk;

    dcgi_config_bank #(.SILICON_REV(REV), .PART_ID(PID)) u_dut (
        .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_be(reg_be), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_win_local(reg_win_local),
        .reg_win_chan(reg_win_chan), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .ch_rx_req(ch_rx_req), .ch_rxto_req(ch_rxto_req), .ch_tx_req(ch_tx_req),
        .ch_ms_req(ch_ms_req), .wake_activity(wake_activity), .timer_timeout(timer_timeout),
        .pin_in(pin_in), .chan_soft_reset(chan_soft_reset), .oversample_eight(oversample_eight),
        .oversample_four(oversample_four), .chan_sleep(chan_sleep), .timer_divisor(timer_divisor),
        .timer_cmd(timer_cmd), .timer_cmd_stb(timer_cmd_stb), .timer_irq_en(timer_irq_en),
        .eeprom_ctrl(eeprom_ctrl), .pin_out(pin_out), .pin_oe(pin_oe));

    dcgi_host_model u_host (
        .mclk(mclk), .reg_addr(reg_addr), .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_win_local(reg_win_local), .reg_win_chan(reg_win_chan),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        u_host.wr(a, be, d, 1'b0, 3'h0);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [3:0] be, input logic [31:0] e);
        logic [31:0] d;
        logic ok;
        u_host.rd(a, be, d, ok);
        if (!ok) begin
            err_total++;
            give_verdict();
        end else
            `CHK(d, e)
    endtask

    task automatic t_reset();
        `CHK({chan_soft_reset, oversample_eight, oversample_four, chan_sleep, timer_divisor,
              eeprom_ctrl, pin_out, pin_oe}, 88'h0)
        rchk(OFF_IRQ_FLAGS, 4'hF, 32'h0000_0000);
        rchk(OFF_TMR_CMD, 4'hF, 32'h0000_0000);
        rchk(OFF_OVS8, 4'hF, 32'h0000_0000);
        rchk(OFF_REV, 4'hF, {16'h0000, PID, REV});
        rchk(OFF_LVL_LO, 4'hF, 32'hFF00_0000);
        rchk(OFF_OD_LO, 4'hF, 32'h0000_0000);
        rchk(OFF_INV_HI, 4'hF, 32'h0000_FF00);
        $display("t_reset done");
    endtask

    task automatic t_rw();
        wr(OFF_TMR_CMD, 4'hF, 32'h3C5A_7700);
        rchk(OFF_TMR_CMD, 4'hF, 32'h3C5A_0000);
        `CHK(timer_divisor, 16'h3C5A)
        wr(OFF_REV, 4'hF, 32'h4411_2233);
        rchk(OFF_REV, 4'hF, {8'h44, 8'h11, PID, REV});
        wr(OFF_LVL_LO, 4'hF, 32'h0012_3456);
        rchk(OFF_LVL_LO, 4'hF, 32'h0012_3456);
        wr(OFF_OD_LO, 4'hF, 32'h0F21_4301);
        rchk(OFF_OD_LO, 4'hF, 32'h0F00_4301);
        wr(OFF_INV_HI, 4'hF, 32'hFFFF_6600);
        rchk(OFF_INV_HI, 4'hF, 32'h00FF_6600);
        `CHK({pin_out, pin_oe}, 32'h2156_90CB)
        wr(8'hA0, 4'hF, 32'hFFFF_FFFF);
        rchk(8'hA0, 4'hF, 32'h0000_0000);
        wr(OFF_OVS8, 4'hF, 32'hA511_3CC3);
        `CHK(chan_soft_reset, 8'h11)
        cyc(1);
        `CHK(chan_soft_reset, 8'h00)
        rchk(OFF_OVS8, 4'hF, 32'hA500_3CC3);
        u_host.wr(OFF_OVS8, 4'hF, 32'hFFFF_FFFF, 1'b1, 3'h3);
        `CHK(chan_soft_reset, 8'h08)
        rchk(OFF_OVS8, 4'hF, 32'hAD00_3CCB);
        `CHK({chan_sleep, oversample_four, oversample_eight}, 24'hAD3CCB)
        $display("t_rw done");
    endtask

    task automatic t_codes();
        ch_rx_req = 8'h11;
        ch_rxto_req = 8'h02;
        ch_tx_req = 8'h07;
        ch_ms_req = 8'h18;
        cyc(2);
        rchk(OFF_IRQ_FLAGS, 4'hF, {CODE_NONE, CODE_NONE, CODE_NONE, CODE_RX, CODE_MODEM, CODE_TX,
             CODE_RXTO, CODE_RX, 8'h1F});
        rchk(OFF_IRQ_FLAGS, 4'h2, 32'h0000_D100);
        wr(OFF_IRQ_FLAGS, 4'hF, 32'h0000_0000);
        rchk(OFF_IRQ_FLAGS, 4'h1, 32'h0000_001F);
        ch_rx_req = 8'h00;
        ch_rxto_req = 8'h00;
        ch_tx_req = 8'h00;
        ch_ms_req = 8'h00;
        cyc(2);
        rchk(OFF_IRQ_FLAGS, 4'hF, 32'h0000_0000);
        $display("t_codes done");
    endtask

    task automatic t_wake();
        wr(OFF_SLEEP, 4'h8, 32'h7F00_0000);
        cyc(3);
        wr(OFF_SLEEP, 4'h8, 32'h0000_0000);
        cyc(3);
        rchk(OFF_IRQ_FLAGS, 4'hF, 32'h0000_0000);
        wr(OFF_SLEEP, 4'h8, 32'hFF00_0000);
        cyc(3);
        `CHK(chan_sleep, SLEEP_ALL)
        wr(OFF_SLEEP, 4'h8, 32'h0000_0000);
        cyc(3);
        rchk(OFF_IRQ_FLAGS, 4'h2, 32'h0000_0000);
        rchk(OFF_IRQ_FLAGS, 4'hF, 32'h0000_0001);
        rchk(OFF_IRQ_FLAGS, 4'hF, 32'h0000_0000);
        $display("t_wake done");
    endtask

    task automatic t_timer();
        wr(OFF_TMR_CMD, 4'h1, {28'h0, TCMD_IRQ_EN});
        `CHK({timer_cmd_stb, timer_cmd, timer_irq_en}, {1'b1, TCMD_IRQ_EN, 1'b1})
        timer_timeout = 1'b1;
        cyc(1);
        timer_timeout = 1'b0;
        cyc(2);
        rchk(OFF_IRQ_FLAGS, 4'hF, {21'h0, CODE_TIMER, 8'h01});
        rchk(OFF_TMR_CMD, 4'h1, 32'h0000_0001);
        rchk(OFF_TMR_CMD, 4'h1, 32'h0000_0000);
        rchk(OFF_IRQ_FLAGS, 4'hF, 32'h0000_0000);
        $display("t_timer done");
    endtask

    task automatic t_pin();
        wr(OFF_LVL_LO, 4'h8, 32'hFF00_0000);
        ch_rx_req = 8'h01;
        pin_in = 16'h0004;
        cyc(3);
        rchk(OFF_IRQ_FLAGS, 4'hF, {21'h0, CODE_RX, 8'h01});
        ch_rx_req = 8'h00;
        cyc(2);
        rchk(OFF_IRQ_FLAGS, 4'hF, {21'h0, CODE_PIN, 8'h01});
        rchk(OFF_LVL_LO, 4'h1, 32'h0000_0016);
        cyc(1);
        rchk(OFF_IRQ_FLAGS, 4'hF, 32'h0000_0000);
        $display("t_pin done");
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        #1;
        reset = 1'b0;
        t_reset();
        t_rw();
        t_codes();
        t_wake();
        t_timer();
        t_pin();
        give_verdict();
    end
endmodule
